// ===== rtl/pcl_pkg.sv
// Constants, register map and carrier types for the programmable pad cell
package pcl_pkg;

    // Bus geometry
    localparam int unsigned PCL_ADDR_W = 8;
    localparam int unsigned PCL_DATA_W = 32;

    // Register byte offsets
    localparam logic [7:0] PCL_OFF_CTRL = 8'h00;
    localparam logic [7:0] PCL_OFF_DELAY = 8'h04;
    localparam logic [7:0] PCL_OFF_ROUTE = 8'h08;
    localparam logic [7:0] PCL_OFF_INVERT = 8'h0C;
    localparam logic [7:0] PCL_OFF_STATUS = 8'h10;

    // Control register fields
    localparam int unsigned PCL_CTRL_LOCK_BIT = 0;

    // Delay register fields
    localparam int unsigned PCL_DLY_UNREG_LSB = 0;
    localparam int unsigned PCL_DLY_REG_LSB = 4;
    localparam int unsigned PCL_DLY_AUTO_BIT = 7;

    // Route register fields
    localparam int unsigned PCL_RT_OUT_REG_BIT = 0;
    localparam int unsigned PCL_RT_EN_REG_BIT = 1;
    localparam int unsigned PCL_RT_OUT_DDR_BIT = 2;
    localparam int unsigned PCL_RT_EN_DDR_BIT = 3;
    localparam int unsigned PCL_RT_CE_USE_LSB = 4;
    localparam int unsigned PCL_RT_LATCH_LSB = 8;
    localparam int unsigned PCL_RT_SYNC_LSB = 16;
    localparam int unsigned PCL_RT_SRHIGH_LSB = 24;

    // Status register fields
    localparam int unsigned PCL_ST_LOCKED_BIT = 0;
    localparam int unsigned PCL_ST_MISMATCH_BIT = 1;
    localparam int unsigned PCL_ST_PAD_BIT = 2;
    localparam int unsigned PCL_ST_CAP_UP_BIT = 3;
    localparam int unsigned PCL_ST_CAP_LO_BIT = 4;
    localparam int unsigned PCL_ST_OE_BIT = 5;
    localparam int unsigned PCL_ST_OUT_BIT = 6;

    // Invert register: fabric inputs in the low bits, pad input above
    localparam int unsigned PCL_FAB_W = 13;
    localparam int unsigned PCL_INV_W = 14;
    localparam int unsigned PCL_INV_PAD_BIT = 13;

    // Delay settings
    localparam int unsigned PCL_TAPS = 6;
    localparam logic [3:0] PCL_UNREG_MAX = 4'hC;
    localparam logic [3:0] PCL_UNREG_HALF = 4'h6;
    localparam logic [3:0] PCL_UNREG_RESET = 4'h0;
    localparam logic [2:0] PCL_REG_MAX = 3'h6;
    localparam logic [2:0] PCL_REG_HALF = 3'h3;
    localparam logic [2:0] PCL_REG_RESET = 3'h0;
    localparam logic [2:0] PCL_REG_TAP_STEP = 3'h2;

    // Storage elements: upper/lower pairs of input, output, enable paths
    localparam int unsigned PCL_ELEMS = 6;
    localparam int unsigned PCL_IN_ELEMS = 2;

    // Reset values
    localparam logic [31:0] PCL_ROUTE_RESET = 32'h0000_0000;
    localparam logic [13:0] PCL_INVERT_RESET = 14'h0000;
    localparam logic [31:0] PCL_ZERO = 32'h0000_0000;

    // Cell life: configuration, then operation
    typedef enum logic {
        PCL_CONFIG = 1'b0,
        PCL_RUN = 1'b1
    } pcl_mode_t;

    // Fabric-side inputs, all individually invertible
    typedef struct packed {
        logic drive_enable_lower;
        logic drive_enable_upper;
        logic out_data_lower;
        logic out_data_upper;
        logic force_opposite_input;
        logic force_initial_input;
        logic tce;
        logic oce;
        logic ice;
        logic otclk_lower;
        logic otclk_upper;
        logic iclk_lower;
        logic iclk_upper;
    } pcl_fabric_t;

    // Static mode of one storage element
    typedef struct packed {
        logic latch;
        logic sync;
        logic srhigh;
        logic ce_used;
    } pcl_store_cfg_t;

endpackage : pcl_pkg

// ===== rtl/pcl_store.sv
// One pad-cell storage element: flip-flop or latch with force controls
`timescale 1ns/10ps
module pcl_store (
    input wire logic CLOCK_IN, // System clock
    input wire logic RST_N_IN, // Synchronous reset, active low
    input wire logic D_IN, // Data input
    input wire logic CK_IN, // Element clock level from fabric
    input wire logic CE_IN, // Clock enable level
    input wire logic SR_IN, // Force-initial input
    input wire logic REV_IN, // Force-opposite input
    input wire pcl_pkg::pcl_store_cfg_t CFG_IN, // Static mode
    output logic Q_OUT // Stored value
);

    logic ck_prev;
    logic ck_rise;
    logic ce_eff;
    logic force_now;

    // Previous clock level for edge detection
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            ck_prev <= 1'b0;
        end else begin
            ck_prev <= CK_IN;
        end
    end

    // Edge, enable and force qualification
    assign ck_rise = CK_IN & ~ck_prev;
    assign ce_eff = CE_IN | ~CFG_IN.ce_used; // R15
    assign force_now = (SR_IN | REV_IN) & (CFG_IN.sync ? ck_rise : 1'b1);

    // Stored value
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            Q_OUT <= 1'b0;
        end else if (force_now) begin
            if (SR_IN && REV_IN) begin
                Q_OUT <= 1'b0; // R16
            end else begin
                Q_OUT <= SR_IN ? CFG_IN.srhigh : ~CFG_IN.srhigh;
            end
        end else if (CFG_IN.latch) begin
            if (CK_IN && ce_eff) begin
                Q_OUT <= D_IN;
            end
        end else if (ck_rise && ce_eff) begin
            Q_OUT <= D_IN; // R15
        end
    end

endmodule : pcl_store

// ===== rtl/pcl_pad_cell.sv
// Programmable pad cell: input delay, three paths, APB configuration
//
// Overview of operation
// R1: Pad signal passes optional delay straight to the direct fabric input, unstored.
// R2: After the delay, an element pair feeds upper and lower captured inputs.
// R3: Output data reaches the pad through a mux, direct or via element pair.
// R4: Enable lines pass a mux, optionally via element pair, deciding pad drive.
// R5: Every cell input, clocks and forces included, has its own inversion.
// R6: Input-only variant keeps input path and drops all output and enable logic.
// R7: Input delay is a bypassable coarse element then a six-tap line.
// R8: All six taps serve the direct route; with coarse choice, twelve settings.
// R9: Three taps serve the registered route; with coarse choice, six settings.
// R10: Coarse element is engaged or bypassed for both routes together.
// R11: Tap settings load at configuration time and stay fixed in operation.
// R12: Direct-route setting accepts zero to twelve; zero bypasses all delay (here zero still gets coarse delay when the registered setting uses it).
// R13: Settings are held per input; registered setting defaults to automatic.
// R14: Software picks both settings from the same half when both are used.
// R15: Elements load on clock edge only with enable; unconnected enable is on.
// R16: Force-initial and force-opposite together give the element a zero.
// R17: Mux route selections are static, loaded with the delay settings.
`timescale 1ns/10ps
module pcl_pad_cell #(
    parameter int unsigned COARSE_LEN = 4, // Coarse delay stages
    parameter logic [2:0] AUTO_SETTING = 3'h3, // Registered setting under auto
    parameter bit INPUT_ONLY = 1'b0 // Reduced input-only variant
) (
    input wire logic CLOCK_IN, // System clock, 125 MHz
    input wire logic RST_N_IN, // Synchronous reset, active low
    input wire logic PSEL_IN, // APB select
    input wire logic PENABLE_IN, // APB enable
    input wire logic PWRITE_IN, // APB direction
    input wire logic [pcl_pkg::PCL_ADDR_W-1:0] PADDR_IN, // APB byte address
    input wire logic [pcl_pkg::PCL_DATA_W-1:0] PWDATA_IN, // APB write data
    output logic PREADY_OUT, // APB ready
    output logic [pcl_pkg::PCL_DATA_W-1:0] PRDATA_OUT, // APB read data
    output logic PSLVERR_OUT, // APB error
    input wire logic PAD_IN, // Pad level seen by the receiver
    output logic PAD_OUT, // Level driven onto the pad
    output logic PAD_OE_OUT, // Pad driver enable, high drives
    input wire pcl_pkg::pcl_fabric_t FABRIC_IN, // Fabric control and data
    output logic DIRECT_INPUT_OUT, // Delayed pad level, unstored
    output logic CAPTURED_INPUT_UPPER_OUT, // Upper captured input
    output logic CAPTURED_INPUT_LOWER_OUT // Lower captured input
);

    localparam int unsigned N_ELEMS = INPUT_ONLY ? pcl_pkg::PCL_IN_ELEMS : pcl_pkg::PCL_ELEMS;

    pcl_pkg::pcl_mode_t mode;
    logic [3:0] unreg_tap_setting;
    logic [2:0] registered_tap_setting;
    logic reg_auto;
    logic [31:0] route;
    logic [pcl_pkg::PCL_INV_W-1:0] invert;
    pcl_pkg::pcl_fabric_t fab;
    logic pad_lvl;
    logic [COARSE_LEN-1:0] coarse;
    logic [pcl_pkg::PCL_TAPS:0] taps;
    logic [2:0] reg_eff;
    logic coarse_use;
    logic [2:0] unreg_tap;
    logic [2:0] reg_tap;
    logic mismatch;
    logic [pcl_pkg::PCL_ELEMS-1:0] elem_q;
    logic [pcl_pkg::PCL_ELEMS-1:0] elem_d;
    logic [pcl_pkg::PCL_ELEMS-1:0] elem_ck;
    logic [pcl_pkg::PCL_ELEMS-1:0] elem_ce;
    logic setup;
    logic commit;
    logic cfg_write_ok;
    logic next_err;
    logic [31:0] next_rdata;
    logic [31:0] status;
    logic [3:0] wr_unreg;
    logic [2:0] wr_reg;

    // True when a direct-route setting uses the coarse element
    function automatic logic unreg_coarse(input logic [3:0] s);
        unreg_coarse = s > pcl_pkg::PCL_UNREG_HALF;
    endfunction : unreg_coarse

    // True when a registered-route setting uses the coarse element
    function automatic logic reg_coarse(input logic [2:0] s);
        reg_coarse = s > pcl_pkg::PCL_REG_HALF;
    endfunction : reg_coarse

    // Input polarity applied to all fabric signals
    assign fab = pcl_pkg::pcl_fabric_t'(FABRIC_IN ^ invert[pcl_pkg::PCL_FAB_W-1:0]); // R5

    // APB phase decode
    assign setup = PSEL_IN & ~PENABLE_IN;
    assign commit = PSEL_IN & PENABLE_IN & PREADY_OUT;
    assign cfg_write_ok = (mode == pcl_pkg::PCL_CONFIG); // R11
    assign wr_unreg = PWDATA_IN[pcl_pkg::PCL_DLY_UNREG_LSB +: 4];
    assign wr_reg = PWDATA_IN[pcl_pkg::PCL_DLY_REG_LSB +: 3];

    // Status word built from live cell state
    always_comb begin
        status = pcl_pkg::PCL_ZERO;
        status[pcl_pkg::PCL_ST_LOCKED_BIT] = (mode == pcl_pkg::PCL_RUN);
        status[pcl_pkg::PCL_ST_MISMATCH_BIT] = mismatch;
        status[pcl_pkg::PCL_ST_PAD_BIT] = pad_lvl;
        status[pcl_pkg::PCL_ST_CAP_UP_BIT] = CAPTURED_INPUT_UPPER_OUT;
        status[pcl_pkg::PCL_ST_CAP_LO_BIT] = CAPTURED_INPUT_LOWER_OUT;
        status[pcl_pkg::PCL_ST_OE_BIT] = PAD_OE_OUT;
        status[pcl_pkg::PCL_ST_OUT_BIT] = PAD_OUT;
    end

    // Read data and error decode for the setup cycle
    always_comb begin
        next_rdata = pcl_pkg::PCL_ZERO;
        next_err = 1'b0;
        unique case (PADDR_IN)
            pcl_pkg::PCL_OFF_CTRL: begin
                next_rdata[pcl_pkg::PCL_CTRL_LOCK_BIT] = (mode == pcl_pkg::PCL_RUN);
            end
            pcl_pkg::PCL_OFF_DELAY: begin
                next_rdata[pcl_pkg::PCL_DLY_UNREG_LSB +: 4] = unreg_tap_setting;
                next_rdata[pcl_pkg::PCL_DLY_REG_LSB +: 3] = registered_tap_setting;
                next_rdata[pcl_pkg::PCL_DLY_AUTO_BIT] = reg_auto;
                next_err = PWRITE_IN & (~cfg_write_ok | (wr_unreg > pcl_pkg::PCL_UNREG_MAX)
                    | (wr_reg > pcl_pkg::PCL_REG_MAX));
            end
            pcl_pkg::PCL_OFF_ROUTE: begin
                next_rdata = route;
                next_err = PWRITE_IN & ~cfg_write_ok;
            end
            pcl_pkg::PCL_OFF_INVERT: begin
                next_rdata[pcl_pkg::PCL_INV_W-1:0] = invert;
                next_err = PWRITE_IN & ~cfg_write_ok;
            end
            pcl_pkg::PCL_OFF_STATUS: begin
                next_rdata = status;
                next_err = PWRITE_IN;
            end
            default: begin
                next_err = 1'b1;
            end
        endcase
    end

    // Ready raised for the access cycle after every setup
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            PREADY_OUT <= 1'b0;
        end else begin
            PREADY_OUT <= setup;
        end
    end

    // Read data and error captured in the setup cycle
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            PRDATA_OUT <= pcl_pkg::PCL_ZERO;
            PSLVERR_OUT <= 1'b0;
        end else if (setup) begin
            PRDATA_OUT <= PWRITE_IN ? pcl_pkg::PCL_ZERO : next_rdata;
            PSLVERR_OUT <= next_err;
        end
    end

    // Configuration to operation; only reset returns to configuration
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            mode <= pcl_pkg::PCL_CONFIG;
        end else if (commit && PWRITE_IN && !PSLVERR_OUT && PADDR_IN == pcl_pkg::PCL_OFF_CTRL
            && PWDATA_IN[pcl_pkg::PCL_CTRL_LOCK_BIT]) begin
            mode <= pcl_pkg::PCL_RUN; // R11
        end
    end

    // Delay settings, writable only during configuration
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            unreg_tap_setting <= pcl_pkg::PCL_UNREG_RESET; // R12
            registered_tap_setting <= pcl_pkg::PCL_REG_RESET;
            reg_auto <= 1'b1; // R13
        end else if (commit && PWRITE_IN && !PSLVERR_OUT
            && PADDR_IN == pcl_pkg::PCL_OFF_DELAY) begin
            unreg_tap_setting <= wr_unreg; // R11
            registered_tap_setting <= wr_reg;
            reg_auto <= PWDATA_IN[pcl_pkg::PCL_DLY_AUTO_BIT];
        end
    end

    // Route and element modes, static after configuration
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            route <= pcl_pkg::PCL_ROUTE_RESET;
        end else if (commit && PWRITE_IN && !PSLVERR_OUT
            && PADDR_IN == pcl_pkg::PCL_OFF_ROUTE) begin
            route <= PWDATA_IN; // R17
        end
    end

    // Per-input inversion selections
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            invert <= pcl_pkg::PCL_INVERT_RESET;
        end else if (commit && PWRITE_IN && !PSLVERR_OUT
            && PADDR_IN == pcl_pkg::PCL_OFF_INVERT) begin
            invert <= PWDATA_IN[pcl_pkg::PCL_INV_W-1:0]; // R5
        end
    end

    // Effective registered setting and shared coarse choice
    assign reg_eff = reg_auto ? AUTO_SETTING : registered_tap_setting; // R13
    assign coarse_use = (unreg_tap_setting != pcl_pkg::PCL_UNREG_RESET)
        ? unreg_coarse(unreg_tap_setting) : reg_coarse(reg_eff); // R10
    assign mismatch = (unreg_tap_setting != pcl_pkg::PCL_UNREG_RESET)
        && (reg_eff != pcl_pkg::PCL_REG_RESET)
        && (unreg_coarse(unreg_tap_setting) != reg_coarse(reg_eff)); // R14

    // Tap numbers: direct route any of six, registered route every second
    always_comb begin
        if (unreg_tap_setting == pcl_pkg::PCL_UNREG_RESET) begin
            unreg_tap = 3'h0; // R12
        end else if (unreg_coarse(unreg_tap_setting)) begin
            unreg_tap = 3'(unreg_tap_setting - pcl_pkg::PCL_UNREG_HALF); // R8
        end else begin
            unreg_tap = unreg_tap_setting[2:0]; // R8
        end
    end

    // Registered route uses taps two, four and six
    always_comb begin
        if (reg_eff == pcl_pkg::PCL_REG_RESET) begin
            reg_tap = 3'h0;
        end else if (reg_coarse(reg_eff)) begin
            reg_tap = 3'((reg_eff - pcl_pkg::PCL_REG_HALF) * pcl_pkg::PCL_REG_TAP_STEP); // R9
        end else begin
            reg_tap = 3'(reg_eff * pcl_pkg::PCL_REG_TAP_STEP); // R9
        end
    end

    // Pad sample with its own inversion
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            pad_lvl <= 1'b0;
        end else begin
            pad_lvl <= PAD_IN ^ invert[pcl_pkg::PCL_INV_PAD_BIT]; // R5
        end
    end

    // Coarse delay element
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            coarse <= '0;
        end else begin
            coarse <= {coarse[COARSE_LEN-2:0], pad_lvl}; // R7
        end
    end

    // Head of the tap line, coarse element engaged or bypassed
    assign taps[0] = coarse_use ? coarse[COARSE_LEN-1] : pad_lvl; // R7

    // Six-tap delay line
    genvar t;
    generate
        for (t = 1; t <= pcl_pkg::PCL_TAPS; t++) begin : g_tap
            always_ff @(posedge CLOCK_IN) begin
                if (!RST_N_IN) begin
                    taps[t] <= 1'b0;
                end else begin
                    taps[t] <= taps[t-1]; // R7
                end
            end
        end
    endgenerate

    // Direct fabric input from the selected tap, no storage element
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            DIRECT_INPUT_OUT <= 1'b0;
        end else begin
            DIRECT_INPUT_OUT <= taps[unreg_tap]; // R1
        end
    end

    // Element clocks, enables and data by position
    assign elem_ck = {fab.otclk_lower, fab.otclk_upper, fab.otclk_lower, fab.otclk_upper,
        fab.iclk_lower, fab.iclk_upper};
    assign elem_ce = {fab.tce, fab.tce, fab.oce, fab.oce, fab.ice, fab.ice};
    assign elem_d = {fab.drive_enable_lower, fab.drive_enable_upper, fab.out_data_lower,
        fab.out_data_upper, taps[reg_tap], taps[reg_tap]}; // R2

    // Storage element pairs; input-only cells build just the input pair
    genvar e;
    generate
        for (e = 0; e < pcl_pkg::PCL_ELEMS; e++) begin : g_elem
            if (e < N_ELEMS) begin : g_on
                pcl_store u_store (
                    .CLOCK_IN(CLOCK_IN),
                    .RST_N_IN(RST_N_IN),
                    .D_IN(elem_d[e]),
                    .CK_IN(elem_ck[e]),
                    .CE_IN(elem_ce[e]),
                    .SR_IN(fab.force_initial_input),
                    .REV_IN(fab.force_opposite_input),
                    .CFG_IN({route[pcl_pkg::PCL_RT_LATCH_LSB + e],
                        route[pcl_pkg::PCL_RT_SYNC_LSB + e],
                        route[pcl_pkg::PCL_RT_SRHIGH_LSB + e],
                        route[pcl_pkg::PCL_RT_CE_USE_LSB + e / 2]}),
                    .Q_OUT(elem_q[e])
                );
            end else begin : g_off
                assign elem_q[e] = 1'b0; // R6
            end
        end
    endgenerate

    // Captured inputs held in flip-flops toward the fabric
    always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
            CAPTURED_INPUT_UPPER_OUT <= 1'b0;
            CAPTURED_INPUT_LOWER_OUT <= 1'b0;
        end else begin
            CAPTURED_INPUT_UPPER_OUT <= elem_q[0]; // R2
            CAPTURED_INPUT_LOWER_OUT <= elem_q[1]; // R2
        end
    end

    // Output and enable paths, absent in the input-only variant
    generate
        if (INPUT_ONLY) begin : g_in_only
            always_ff @(posedge CLOCK_IN) begin
                PAD_OUT <= 1'b0; // R6
                PAD_OE_OUT <= 1'b0; // R6
            end
        end else begin : g_full
            logic out_sel;
            logic en_sel;

            // Output mux: direct or element pair, pair alternated by clock level
            always_comb begin
                if (route[pcl_pkg::PCL_RT_OUT_REG_BIT]) begin
                    out_sel = (route[pcl_pkg::PCL_RT_OUT_DDR_BIT] && !fab.otclk_upper)
                        ? elem_q[3] : elem_q[2]; // R3
                end else begin
                    out_sel = (route[pcl_pkg::PCL_RT_OUT_DDR_BIT] && !fab.otclk_upper)
                        ? fab.out_data_lower : fab.out_data_upper; // R3
                end
            end

            // Enable mux: direct or element pair
            always_comb begin
                if (route[pcl_pkg::PCL_RT_EN_REG_BIT]) begin
                    en_sel = (route[pcl_pkg::PCL_RT_EN_DDR_BIT] && !fab.otclk_upper)
                        ? elem_q[5] : elem_q[4]; // R4
                end else begin
                    en_sel = (route[pcl_pkg::PCL_RT_EN_DDR_BIT] && !fab.otclk_upper)
                        ? fab.drive_enable_lower : fab.drive_enable_upper; // R4
                end
            end

            // Pad driver, held off until configuration is locked
            always_ff @(posedge CLOCK_IN) begin
                if (!RST_N_IN) begin
                    PAD_OUT <= 1'b0;
                    PAD_OE_OUT <= 1'b0;
                end else begin
                    PAD_OUT <= out_sel; // R3
                    PAD_OE_OUT <= en_sel && (mode == pcl_pkg::PCL_RUN); // R4
                end
            end
        end
    endgenerate

endmodule : pcl_pad_cell

// ===== tb/pcl_pad_model.sv
// Pad model: resolves the pad from the cell driver and an outside source
`timescale 1ns/10ps
module pcl_pad_model (
    input wire logic drv_in, // Cell output level
    input wire logic oe_in, // Cell driver enable
    input wire logic ext_in, // Outside source level
    output logic pad_out // Resolved pad level
);
    // Cell wins while driving, outside source otherwise
    assign pad_out = oe_in ? drv_in : ext_in;
endmodule : pcl_pad_model

// ===== tb/pcl_pad_cell_chk.sv
// Register port assertions for the pad cell
`timescale 1ns/10ps
module pcl_pad_cell_chk (
    input wire logic CLOCK_IN, // Clock
    input wire logic RST_N_IN, // Reset, active low
    input wire logic PSEL_IN, // Select
    input wire logic PENABLE_IN, // Enable
    input wire logic PWRITE_IN, // Direction
    input wire logic [pcl_pkg::PCL_ADDR_W-1:0] PADDR_IN, // Address
    input wire logic [pcl_pkg::PCL_DATA_W-1:0] PWDATA_IN, // Write data
    input wire logic PREADY_OUT, // Ready
    input wire logic [pcl_pkg::PCL_DATA_W-1:0] PRDATA_OUT, // Read data
    input wire logic PSLVERR_OUT // Error
);
    default clocking cb @(posedge CLOCK_IN); endclocking
    default disable iff (!RST_N_IN);
    // Setup phase and delay writes
    sequence s_setup;
        PSEL_IN && !PENABLE_IN;
    endsequence
    sequence s_dly_wr;
        s_setup ##0 (PWRITE_IN && PADDR_IN == pcl_pkg::PCL_OFF_DELAY);
    endsequence
    // Handshake and refusal checks
    a_ready_follows: assert property (s_setup |=> PREADY_OUT)
        else $error("ready missing after setup");
    a_ready_single: assert property (PREADY_OUT |=> !PREADY_OUT)
        else $error("ready longer than one cycle");
    a_ready_cause: assert property (PREADY_OUT |-> $past(PSEL_IN && !PENABLE_IN))
        else $error("ready without setup");
    a_write_zero: assert property (s_setup ##0 PWRITE_IN |=> PRDATA_OUT == '0)
        else $error("read data not zero on write");
    a_status_ro: assert property (s_setup ##0 (PWRITE_IN && PADDR_IN ==
        pcl_pkg::PCL_OFF_STATUS) |=> PSLVERR_OUT) else $error("status write accepted");
    a_unmapped_err: assert property (s_setup ##0 (PADDR_IN > pcl_pkg::PCL_OFF_STATUS)
        |=> PSLVERR_OUT) else $error("unmapped access accepted");
    a_unreg_range: assert property (s_dly_wr ##0 (PWDATA_IN[3:0] > 4'hC)
        |=> PSLVERR_OUT) else $error("direct setting above range accepted");
    a_reg_range: assert property (s_dly_wr ##0 (PWDATA_IN[6:4] > 3'h6)
        |=> PSLVERR_OUT) else $error("registered setting above range accepted");
    a_rdata_hold: assert property (!(PSEL_IN && !PENABLE_IN) |=>
        $stable(PRDATA_OUT) && $stable(PSLVERR_OUT)) else $error("answer changed");
endmodule : pcl_pad_cell_chk
bind pcl_pad_cell pcl_pad_cell_chk chk_u (.CLOCK_IN, .RST_N_IN, .PSEL_IN, .PENABLE_IN,
    .PWRITE_IN, .PADDR_IN, .PWDATA_IN, .PREADY_OUT, .PRDATA_OUT, .PSLVERR_OUT);

// ===== tb/pcl_pad_cell_tb.sv
// Self-checking bench for the programmable pad cell
`timescale 1ns/10ps
module pcl_pad_cell_tb;
    localparam int COARSE = 4;
    logic clk, rst_n, psel, pen, pwr, pready, pslverr, pad, pad_o, pad_oe, ext;
    logic dir, cu, cl;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    pcl_pkg::pcl_fabric_t fab;
    int err_count = 0;
    int tests_run = 0;
    int cyc = 0;
    // Device and pad
    pcl_pad_cell #(.COARSE_LEN(COARSE)) dut_u (.CLOCK_IN(clk), .RST_N_IN(rst_n),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr),
        .PWDATA_IN(pwdata), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
        .PSLVERR_OUT(pslverr), .PAD_IN(pad), .PAD_OUT(pad_o), .PAD_OE_OUT(pad_oe),
        .FABRIC_IN(fab), .DIRECT_INPUT_OUT(dir), .CAPTURED_INPUT_UPPER_OUT(cu),
        .CAPTURED_INPUT_LOWER_OUT(cl));
    pcl_pad_model pad_u (.drv_in(pad_o), .oe_in(pad_oe), .ext_in(ext), .pad_out(pad));
    // Clock and hang guard
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            wrap_up();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // One checked bus transfer, then an idle cycle
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic ee);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        chk(prdata, w ? 32'h0000_0000 : d);
        chk({31'h0, pslverr}, {31'h0, ee});
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic ee);
        apb(1'b1, a, d, ee);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, x, 1'b0);
    endtask : rd
    // Reset values and refusals
    task automatic t_regs;
        rd(pcl_pkg::PCL_OFF_DELAY, 32'h0000_0080);
        rd(pcl_pkg::PCL_OFF_ROUTE, 32'h0000_0000);
        rd(pcl_pkg::PCL_OFF_INVERT, 32'h0000_0000);
        wr(8'h14, 32'h0000_0000, 1'b1);
        wr(pcl_pkg::PCL_OFF_STATUS, 32'h0000_0000, 1'b1);
        wr(pcl_pkg::PCL_OFF_DELAY, 32'h0000_000D, 1'b1);
        wr(pcl_pkg::PCL_OFF_DELAY, 32'h0000_0070, 1'b1);
    endtask : t_regs
    // Direct route latency per setting
    task automatic t_direct;
        logic [3:0] s[4] = '{4'h0, 4'h3, 4'h7, 4'hC};
        int k, n;
        foreach (s[i]) begin
            wr(pcl_pkg::PCL_OFF_DELAY, {28'h0, s[i]}, 1'b0);
            k = (s[i] > 6) ? int'(s[i]) - 6 + COARSE : int'(s[i]);
            ext <= 1'b0;
            repeat (30) @(posedge clk);
            ext <= 1'b1;
            n = 0;
            do begin
                @(posedge clk);
                n++;
                #1;
            end while (dir !== 1'b1 && n < 40);
            chk(n, 2 + k);
            @(posedge clk);
        end
    endtask : t_direct
    // Forces, inversion and captured input
    task automatic t_force;
        wr(pcl_pkg::PCL_OFF_ROUTE, 32'h0100_0010, 1'b0);
        fab.force_initial_input <= 1'b1;
        repeat (4) @(posedge clk);
        chk({31'h0, cu}, 32'h0000_0001);
        fab.force_opposite_input <= 1'b1;
        repeat (4) @(posedge clk);
        chk({31'h0, cu}, 32'h0000_0000);
        fab.force_initial_input <= 1'b0;
        fab.force_opposite_input <= 1'b0;
        wr(pcl_pkg::PCL_OFF_INVERT, 32'h0000_0080, 1'b0);
        repeat (4) @(posedge clk);
        chk({31'h0, cu}, 32'h0000_0001);
        wr(pcl_pkg::PCL_OFF_INVERT, 32'h0000_0000, 1'b0);
        ext <= 1'b0;
        fab.iclk_lower <= 1'b1;
        repeat (20) @(posedge clk);
        chk({30'h0, cu, cl}, 32'h0000_0002);
        {fab.iclk_upper, fab.ice} <= 2'h3;
        repeat (20) @(posedge clk);
        chk({30'h0, cu, cl}, 32'h0000_0000);
    endtask : t_force
    // Registered output, direct enable, lock
    task automatic t_out;
        wr(pcl_pkg::PCL_OFF_ROUTE, 32'h0000_0005, 1'b0);
        wr(pcl_pkg::PCL_OFF_CTRL, 32'h0000_0001, 1'b0);
        ext <= 1'b1;
        fab.out_data_upper <= 1'b1;
        fab.out_data_lower <= 1'b1;
        fab.drive_enable_upper <= 1'b1;
        fab.drive_enable_lower <= 1'b1;
        repeat (4) @(posedge clk);
        chk({30'h0, pad_oe, pad}, 32'h0000_0002);
        fab.otclk_upper <= 1'b1;
        repeat (4) @(posedge clk);
        chk({30'h0, pad_oe, pad}, 32'h0000_0003);
        fab.drive_enable_upper <= 1'b0;
        fab.drive_enable_lower <= 1'b0;
        ext <= 1'b0;
        repeat (4) @(posedge clk);
        chk({30'h0, pad_oe, pad}, 32'h0000_0000);
        wr(pcl_pkg::PCL_OFF_DELAY, 32'h0000_0001, 1'b1);
        wr(pcl_pkg::PCL_OFF_ROUTE, 32'h0000_0000, 1'b1);
        rd(pcl_pkg::PCL_OFF_CTRL, 32'h0000_0001);
    endtask : t_out
    task automatic wrap_up;
        if (err_count == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : wrap_up
    // Main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        {psel, pen, pwr, ext} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        fab = '0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_regs();
        t_direct();
        t_force();
        t_out();
        wrap_up();
    end
endmodule : pcl_pad_cell_tb
